/* core/vtas_pkg.sv */
package vtas_pkg;
   // clock rate and conversion timing
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned CONV_TIME_US = 711;
   localparam int unsigned CONV_CYCLES = CONV_TIME_US * CLK_MHZ;
   localparam int unsigned REMOTE_MEAS_TIME_US = 38000;
   localparam int unsigned AVG_COUNT = 16;
   localparam int unsigned REMOTE_SAMPLE_CYCLES = REMOTE_MEAS_TIME_US * CLK_MHZ / AVG_COUNT;
   localparam int unsigned TIMER_W = 20;
   localparam int unsigned CNT_W = 5;
   localparam int unsigned SUM_W = 14;
   localparam int unsigned AVG_SHIFT = 4;
   localparam int unsigned NUM_CH = 5;

   // register offsets
   localparam logic [7:0] ADDR_CORE_VALUE = 8'h21;
   localparam logic [7:0] ADDR_SUPPLY_VALUE = 8'h22;
   localparam logic [7:0] ADDR_REMOTE1_VALUE = 8'h25;
   localparam logic [7:0] ADDR_LOCAL_VALUE = 8'h26;
   localparam logic [7:0] ADDR_REMOTE2_VALUE = 8'h27;
   localparam logic [7:0] ADDR_LOW_LIMIT = 8'h46;
   localparam logic [7:0] ADDR_HIGH_LIMIT = 8'h47;
   localparam logic [7:0] ADDR_CHSEL = 8'h55;
   localparam logic [7:0] ADDR_CFG2 = 8'h73;
   localparam logic [7:0] ADDR_EXT1 = 8'h76;
   localparam logic [7:0] ADDR_EXT2 = 8'h77;

   // reset values
   localparam logic [7:0] RST_LOW_LIMIT = 8'h00;
   localparam logic [7:0] RST_HIGH_LIMIT = 8'hff;
   localparam logic [7:0] RST_REG = 8'h00;

   // field positions
   localparam int unsigned CFG2_AVG_OFF_BIT = 4;
   localparam int unsigned CFG2_BYPASS_BIT = 5;
   localparam int unsigned CFG2_SINGLE_BIT = 6;
   localparam int unsigned CHSEL_LSB = 5;
   localparam int unsigned EXT1_CORE_LSB = 2;
   localparam int unsigned EXT1_SUPPLY_LSB = 4;
   localparam int unsigned EXT2_REMOTE1_LSB = 2;
   localparam int unsigned EXT2_LOCAL_LSB = 4;
   localparam int unsigned EXT2_REMOTE2_LSB = 6;

   // front-end channel codes
   localparam logic [2:0] CH_CORE = 3'h1;
   localparam logic [2:0] CH_SUPPLY = 3'h2;
   localparam logic [2:0] CH_REMOTE1 = 3'h5;
   localparam logic [2:0] CH_LOCAL = 3'h6;
   localparam logic [2:0] CH_REMOTE2 = 3'h7;

   // internal channel indices, also the round-robin order
   localparam logic [2:0] IDX_CORE = 3'h0;
   localparam logic [2:0] IDX_SUPPLY = 3'h1;
   localparam logic [2:0] IDX_REMOTE1 = 3'h2;
   localparam logic [2:0] IDX_LOCAL = 3'h3;
   localparam logic [2:0] IDX_REMOTE2 = 3'h4;

   // offset-64 shift of a 10-bit temperature code
   localparam logic [10:0] TEMP_OFFSET64 = 11'h100;

   typedef logic [9:0] vtas_code_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_START = 3'b010,
      ST_WAIT = 3'b100
   } vtas_state_e;
endpackage

/* core/vtas_avg_if.sv */
`timescale 1ns/1ps
// samples into the averager, results back to the sequencer
interface vtas_avg_if;
   logic restart;
   logic avg_off;
   logic sample_valid;
   vtas_pkg::vtas_code_t sample_code;
   logic result_valid;
   vtas_pkg::vtas_code_t result;
   modport seq (
      output restart, avg_off, sample_valid, sample_code,
      input result_valid, result
   );
   modport avg (
      input restart, avg_off, sample_valid, sample_code,
      output result_valid, result
   );
endinterface

/* core/vtas_averager.sv */
`timescale 1ns/1ps
module vtas_averager (
   // clock, reset and freeze
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   // sample stream and result
   vtas_avg_if.avg avg
);
   logic [vtas_pkg::SUM_W-1:0] sum; // running total of samples
   logic [vtas_pkg::CNT_W-1:0] count; // samples taken so far
   logic [vtas_pkg::SUM_W-1:0] next_sum;
   logic [vtas_pkg::CNT_W-1:0] limit;

   // 16 codes of 1023 fit in 14 bits, so the total never wraps
   assign next_sum = sum + {4'h0, avg.sample_code};
   assign limit = avg.avg_off ? 5'h01 : 5'(vtas_pkg::AVG_COUNT);

   // accumulate; the mean of 10-bit codes stays inside 0..1023
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sum <= '0;
         count <= '0;
         avg.result_valid <= 1'b0;
         avg.result <= 10'h000;
      end else if (i_clk_en) begin
         avg.result_valid <= 1'b0;
         if (avg.restart) begin
            // a config change drops a half-built average
            sum <= '0;
            count <= '0;
         end else if (avg.sample_valid) begin
            if (count + 5'h01 == limit) begin
               avg.result <= avg.avg_off ? avg.sample_code : next_sum[vtas_pkg::SUM_W-1:vtas_pkg::AVG_SHIFT];
               avg.result_valid <= 1'b1;
               sum <= '0;
               count <= '0;
            end else begin
               sum <= next_sum;
               count <= count + 5'h01;
            end
         end
      end
   end

   sequence s_raw_sample;
      i_clk_en && avg.sample_valid && avg.avg_off && !avg.restart;
   endsequence
   property p_avg_off;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      s_raw_sample |=> avg.result_valid && (avg.result == $past(avg.sample_code));
   endproperty
   a_avg_off: assert property (p_avg_off) else $error("averaging off did not pass sample through");

   property p_sixteen;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      i_clk_en && avg.sample_valid && !avg.avg_off && !avg.restart && (count == 5'h0f) |=> avg.result_valid;
   endproperty
   a_sixteen: assert property (p_sixteen) else $error("no result after sixteen samples");
endmodule // vtas_averager

/* core/vtas_adc_sequencer.sv */
`timescale 1ns/1ps
// Summary of operation
// - rail outside limits sets its status bit
// - rail limit crossing pulls alert low
// - 711 us samples, 16 averaged per result
// - extended read freezes matching value registers
// - config two bit 4 disables averaging
// - config two bit 5 bypasses rail attenuator
// - config two bit 6 converts one channel
// - single channel comes from 0x55 bits 7:5
// - channel codes 001,010,101,110,111 decoded
// - results are 10-bit codes, saturating
// - temperature upper byte, twos or offset 64
// - temperature range in quarter-degree steps
// - remote result averages 16, 38 ms
// - temperature low bits kept in 0x77
// - alert released after status read, if clear
module vtas_adc_sequencer #(
   parameter int unsigned CONV_CYCLES = vtas_pkg::CONV_CYCLES,
   parameter int unsigned REMOTE_CYCLES = vtas_pkg::REMOTE_SAMPLE_CYCLES
) (
   // clock, reset and freeze
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   // register port from the serial bus engine
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   // status handshake and temperature format
   input wire logic i_status_read,
   input wire logic i_twos_complement,
   // analog front end
   output logic o_adc_start,
   output logic [2:0] o_adc_channel,
   output logic o_atten_bypass,
   input wire logic i_adc_done,
   input wire logic [9:0] i_adc_code,
   // alert pin, open drain, and rail status
   output logic o_alert_out_n,
   output logic o_alert_out_n_oe,
   output logic o_core_rail_alarm
);
   localparam int unsigned NUM_CH = vtas_pkg::NUM_CH;

   vtas_pkg::vtas_code_t value [NUM_CH]; // 10-bit results per channel
   logic [NUM_CH-1:0] lock; // value frozen until read
   logic [NUM_CH-1:0] rd_value_hit; // host reads a value register
   logic [NUM_CH-1:0] rd_ext_hit; // host reads its extended register
   logic [7:0] low_limit; // rail low limit
   logic [7:0] high_limit; // rail high limit
   logic [7:0] chsel_reg; // fan byte with channel select on top
   logic [7:0] cfg2; // averaging, bypass, single mode
   logic [2:0] cur_idx; // channel being averaged
   logic [2:0] next_idx;
   logic [vtas_pkg::TIMER_W-1:0] timer; // cycles to next start
   logic [vtas_pkg::TIMER_W-1:0] period;
   vtas_pkg::vtas_state_e state;
   logic rail_fault; // last rail result out of limits
   logic fault_event; // this result is out of limits
   vtas_pkg::vtas_code_t stored_code;
   logic cfg_write;
   logic [7:0] next_rdata;
   logic [vtas_pkg::TIMER_W-1:0] gap_cnt; // helper: cycles since last start
   logic seen_start; // helper: a start has happened

   vtas_avg_if avg ();

   // channel index to front-end code
   function automatic logic [2:0] idx_to_code(input logic [2:0] idx);
      case (idx)
         vtas_pkg::IDX_CORE: idx_to_code = vtas_pkg::CH_CORE;
         vtas_pkg::IDX_SUPPLY: idx_to_code = vtas_pkg::CH_SUPPLY;
         vtas_pkg::IDX_REMOTE1: idx_to_code = vtas_pkg::CH_REMOTE1;
         vtas_pkg::IDX_LOCAL: idx_to_code = vtas_pkg::CH_LOCAL;
         default: idx_to_code = vtas_pkg::CH_REMOTE2;
      endcase
   endfunction

   // select code to index; unlisted codes fall back to the core rail
   function automatic logic [2:0] code_to_idx(input logic [2:0] code);
      case (code)
         vtas_pkg::CH_SUPPLY: code_to_idx = vtas_pkg::IDX_SUPPLY;
         vtas_pkg::CH_REMOTE1: code_to_idx = vtas_pkg::IDX_REMOTE1;
         vtas_pkg::CH_LOCAL: code_to_idx = vtas_pkg::IDX_LOCAL;
         vtas_pkg::CH_REMOTE2: code_to_idx = vtas_pkg::IDX_REMOTE2;
         default: code_to_idx = vtas_pkg::IDX_CORE;
      endcase
   endfunction

   // value register address of each channel
   function automatic logic [7:0] value_addr(input int unsigned idx);
      case (idx)
         0: value_addr = vtas_pkg::ADDR_CORE_VALUE;
         1: value_addr = vtas_pkg::ADDR_SUPPLY_VALUE;
         2: value_addr = vtas_pkg::ADDR_REMOTE1_VALUE;
         3: value_addr = vtas_pkg::ADDR_LOCAL_VALUE;
         default: value_addr = vtas_pkg::ADDR_REMOTE2_VALUE;
      endcase
   endfunction

   // temperature channels sit above the two rails
   function automatic logic is_temp(input logic [2:0] idx);
      is_temp = (idx >= vtas_pkg::IDX_REMOTE1);
   endfunction

   // twos complement to offset 64; below -64 degrees clamps to zero
   function automatic vtas_pkg::vtas_code_t to_offset64(input vtas_pkg::vtas_code_t t);
      logic [10:0] s;
      s = {t[9], t} + vtas_pkg::TEMP_OFFSET64;
      to_offset64 = s[10] ? 10'h000 : s[9:0];
   endfunction

   vtas_averager u_avg (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_clk_en(i_clk_en),
      .avg(avg.avg)
   );

   // temperature format applied at store time
   assign stored_code = (is_temp(cur_idx) && !i_twos_complement) ? to_offset64(avg.result) : avg.result;
   assign avg.avg_off = cfg2[vtas_pkg::CFG2_AVG_OFF_BIT];
   assign o_atten_bypass = cfg2[vtas_pkg::CFG2_BYPASS_BIT];
   assign cfg_write = i_reg_wr && ((i_reg_addr == vtas_pkg::ADDR_CFG2) || (i_reg_addr == vtas_pkg::ADDR_CHSEL));
   assign period = is_temp(cur_idx) && (cur_idx != vtas_pkg::IDX_LOCAL) ?
      vtas_pkg::TIMER_W'(REMOTE_CYCLES - 2) : vtas_pkg::TIMER_W'(CONV_CYCLES - 2);

   // per-channel storage and lock
   for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
      assign rd_value_hit[g] = i_reg_rd && (i_reg_addr == value_addr(g));
      assign rd_ext_hit[g] = i_reg_rd && (i_reg_addr == ((g < 2) ? vtas_pkg::ADDR_EXT1 : vtas_pkg::ADDR_EXT2));

      // a locked channel keeps its word so high and low parts stay paired
      always_ff @(posedge i_core_clk or negedge i_rst_n) begin
         if (!i_rst_n) begin
            value[g] <= 10'h000;
            lock[g] <= 1'b0;
         end else if (i_clk_en) begin
            if (rd_value_hit[g]) begin
               lock[g] <= 1'b0;
            end else if (rd_ext_hit[g]) begin
               lock[g] <= 1'b1;
            end
            if (avg.result_valid && (cur_idx == 3'(g)) && !lock[g] && !rd_ext_hit[g]) begin
               value[g] <= stored_code;
            end
         end
      end

      property p_lock_freeze;
         @(posedge i_core_clk) disable iff (!i_rst_n)
         lock[g] |=> $stable(value[g]);
      endproperty
      a_lock_freeze: assert property (p_lock_freeze) else $error("locked value register changed");
   end

   // host-written registers
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         low_limit <= vtas_pkg::RST_LOW_LIMIT;
         high_limit <= vtas_pkg::RST_HIGH_LIMIT;
         chsel_reg <= vtas_pkg::RST_REG;
         cfg2 <= vtas_pkg::RST_REG;
      end else if (i_clk_en && i_reg_wr) begin
         case (i_reg_addr)
            vtas_pkg::ADDR_LOW_LIMIT: low_limit <= i_reg_wdata;
            vtas_pkg::ADDR_HIGH_LIMIT: high_limit <= i_reg_wdata;
            vtas_pkg::ADDR_CHSEL: chsel_reg <= i_reg_wdata;
            vtas_pkg::ADDR_CFG2: cfg2 <= i_reg_wdata;
            default: ; // read-only or unmapped: ignored
         endcase
      end
   end

   // next channel: fixed one in single mode, else round robin
   always_comb begin
      if (cfg2[vtas_pkg::CFG2_SINGLE_BIT]) begin
         next_idx = code_to_idx(chsel_reg[vtas_pkg::CHSEL_LSB +: 3]);
      end else if (cur_idx == vtas_pkg::IDX_REMOTE2) begin
         next_idx = vtas_pkg::IDX_CORE;
      end else begin
         next_idx = cur_idx + 3'h1;
      end
   end

   // channel advances only once a whole result is out of the averager, stored or not
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cur_idx <= vtas_pkg::IDX_CORE;
         o_adc_channel <= vtas_pkg::CH_CORE;
      end else if (i_clk_en && avg.result_valid) begin
         cur_idx <= next_idx;
         o_adc_channel <= idx_to_code(next_idx);
      end
   end

   // sample pacing; a late done only delays the next start
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= vtas_pkg::ST_IDLE;
         timer <= '0;
         o_adc_start <= 1'b0;
         avg.sample_valid <= 1'b0;
         avg.sample_code <= 10'h000;
         avg.restart <= 1'b0;
      end else if (i_clk_en) begin
         o_adc_start <= 1'b0;
         avg.sample_valid <= 1'b0;
         avg.restart <= cfg_write;
         if (timer != '0) begin
            timer <= timer - 1'b1;
         end
         unique case (state)
            vtas_pkg::ST_IDLE: begin
               if (timer == '0) begin
                  state <= vtas_pkg::ST_START;
               end
            end
            vtas_pkg::ST_START: begin
               o_adc_start <= 1'b1;
               timer <= period;
               state <= vtas_pkg::ST_WAIT;
            end
            vtas_pkg::ST_WAIT: begin
               if (i_adc_done) begin
                  avg.sample_valid <= 1'b1;
                  avg.sample_code <= i_adc_code;
                  state <= vtas_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   // out-of-limit check on the upper byte, unsigned
   assign fault_event = avg.result_valid && (cur_idx == vtas_pkg::IDX_CORE) &&
      ((avg.result[9:2] > high_limit) || (avg.result[9:2] < low_limit));

   // fault level tracks the latest rail result
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rail_fault <= 1'b0;
      end else if (i_clk_en && avg.result_valid && (cur_idx == vtas_pkg::IDX_CORE)) begin
         rail_fault <= fault_event;
      end
   end

   // sticky status; a new fault beats a clearing read
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_core_rail_alarm <= 1'b0;
      end else if (i_clk_en) begin
         if (fault_event) begin
            o_core_rail_alarm <= 1'b1;
         end else if (i_status_read && !rail_fault) begin
            o_core_rail_alarm <= 1'b0;
         end
      end
   end

   // open-drain alert: only ever drives low
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_alert_out_n <= 1'b0;
         o_alert_out_n_oe <= 1'b0;
      end else if (i_clk_en) begin
         o_alert_out_n <= 1'b0;
         o_alert_out_n_oe <= o_core_rail_alarm;
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      next_rdata = 8'h00;
      for (int k = 0; k < NUM_CH; k++) begin
         if (i_reg_addr == value_addr(k)) begin
            next_rdata = value[k][9:2];
         end
      end
      case (i_reg_addr)
         vtas_pkg::ADDR_LOW_LIMIT: next_rdata = low_limit;
         vtas_pkg::ADDR_HIGH_LIMIT: next_rdata = high_limit;
         vtas_pkg::ADDR_CHSEL: next_rdata = chsel_reg;
         vtas_pkg::ADDR_CFG2: next_rdata = cfg2;
         vtas_pkg::ADDR_EXT1: begin
            next_rdata[vtas_pkg::EXT1_CORE_LSB +: 2] = value[vtas_pkg::IDX_CORE][1:0];
            next_rdata[vtas_pkg::EXT1_SUPPLY_LSB +: 2] = value[vtas_pkg::IDX_SUPPLY][1:0];
         end
         vtas_pkg::ADDR_EXT2: begin
            next_rdata[vtas_pkg::EXT2_REMOTE1_LSB +: 2] = value[vtas_pkg::IDX_REMOTE1][1:0];
            next_rdata[vtas_pkg::EXT2_LOCAL_LSB +: 2] = value[vtas_pkg::IDX_LOCAL][1:0];
            next_rdata[vtas_pkg::EXT2_REMOTE2_LSB +: 2] = value[vtas_pkg::IDX_REMOTE2][1:0];
         end
         default: ; // value registers handled above
      endcase
   end

   // read data holds until the next read
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_reg_rdata <= 8'h00;
      end else if (i_clk_en && i_reg_rd) begin
         o_reg_rdata <= next_rdata;
      end
   end

   // helper for spacing checks between starts
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         gap_cnt <= '0;
         seen_start <= 1'b0;
      end else if (i_clk_en) begin
         if (o_adc_start) begin
            gap_cnt <= 20'h00001;
            seen_start <= 1'b1;
         end else if (gap_cnt != '1) begin
            gap_cnt <= gap_cnt + 1'b1;
         end
      end
   end

   sequence s_rail_high;
      i_clk_en && fault_event && (avg.result[9:2] > high_limit);
   endsequence
   property p_status_set;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      s_rail_high |=> o_core_rail_alarm;
   endproperty
   a_status_set: assert property (p_status_set) else $error("high limit did not set status");

   property p_alert;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      i_clk_en && $rose(o_core_rail_alarm) |=> o_alert_out_n_oe && !o_alert_out_n;
   endproperty
   a_alert: assert property (p_alert) else $error("alert not driven after status set");

   property p_spacing;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      o_adc_start && seen_start |-> gap_cnt >= vtas_pkg::TIMER_W'(CONV_CYCLES);
   endproperty
   a_spacing: assert property (p_spacing) else $error("conversion started too early");

   property p_bypass;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      i_clk_en && i_reg_wr && (i_reg_addr == vtas_pkg::ADDR_CFG2) |=> o_atten_bypass == $past(i_reg_wdata[5]);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass does not follow config");

   property p_single;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      i_clk_en && avg.result_valid && cfg2[vtas_pkg::CFG2_SINGLE_BIT] && !i_reg_wr &&
      (chsel_reg[7:5] == vtas_pkg::CH_LOCAL) |=> o_adc_channel == vtas_pkg::CH_LOCAL;
   endproperty
   a_single: assert property (p_single) else $error("single mode picked wrong channel");

   property p_release;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      i_clk_en && i_status_read && !rail_fault && !fault_event |=> !o_core_rail_alarm ##1 !o_alert_out_n_oe;
   endproperty
   a_release: assert property (p_release) else $error("alert not released after read");
   property p_compare_low;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      i_clk_en && avg.result_valid && (cur_idx == vtas_pkg::IDX_CORE) && (avg.result[9:2] < low_limit) |=>
      o_core_rail_alarm && rail_fault;
   endproperty
   a_compare_low: assert property (p_compare_low) else $error("low limit miss not flagged");
endmodule // vtas_adc_sequencer

/* testbench/vtas_front_end_model.sv */
`timescale 1ns/1ps
// behavioural analog front end: one answer per start, after a settable delay
module vtas_front_end_model (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // conversion request
   input wire logic i_adc_start,
   input wire logic [2:0] i_adc_channel,
   // analog levels seen by the converter, and answer delay
   input wire logic [3:0] i_delay,
   input wire logic [9:0] i_core_code,
   input wire logic [9:0] i_other_code,
   // conversion answer
   output logic o_adc_done,
   output logic [9:0] o_adc_code
);
   logic busy; // a conversion is in flight
   logic [3:0] cnt; // cycles left before the answer
   logic [2:0] sel; // channel latched at the start

   // code toggles outside done so a stale value is never mistaken for data
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         busy <= 1'b0;
         cnt <= 4'h0;
         sel <= 3'h0;
         o_adc_done <= 1'b0;
         o_adc_code <= 10'h000;
      end else begin
         o_adc_done <= 1'b0;
         o_adc_code <= ~o_adc_code;
         if (i_adc_start) begin
            busy <= 1'b1;
            cnt <= i_delay;
            sel <= i_adc_channel;
         end else if (busy && cnt == 4'h0) begin
            busy <= 1'b0;
            o_adc_done <= 1'b1;
            o_adc_code <= (sel == 3'h1) ? i_core_code : i_other_code;
         end else if (busy) begin
            cnt <= cnt - 4'h1;
         end
      end
   end
endmodule // vtas_front_end_model

/* testbench/test_vtas_adc_sequencer.sv */
`timescale 1ns/1ps
module test_vtas_adc_sequencer;
   logic i_core_clk = 0, i_rst_n = 0, i_reg_wr = 0, i_reg_rd = 0, i_status_read = 0, i_twos_complement = 1;
   logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, rd_val, o_reg_rdata;
   logic [3:0] delay = 4'h3; // front-end answer delay, well inside the period
   logic [9:0] core_code = 10'h2a9, other_code = 10'h065, i_adc_code;
   logic o_adc_start, o_atten_bypass, o_alert_out_n, o_alert_out_n_oe, o_core_rail_alarm, i_adc_done;
   logic [2:0] o_adc_channel;
   int failures = 0, tests_run = 0;
   always #2 i_core_clk = ~i_core_clk;
   // short periods keep a full round robin near two thousand cycles
   vtas_adc_sequencer #(.CONV_CYCLES(20), .REMOTE_CYCLES(30)) u_dut (.i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n), .i_clk_en(1'b1), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
      .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
      .i_status_read(i_status_read), .i_twos_complement(i_twos_complement), .o_adc_start(o_adc_start),
      .o_adc_channel(o_adc_channel), .o_atten_bypass(o_atten_bypass), .i_adc_done(i_adc_done),
      .i_adc_code(i_adc_code), .o_alert_out_n(o_alert_out_n), .o_alert_out_n_oe(o_alert_out_n_oe),
      .o_core_rail_alarm(o_core_rail_alarm));
   vtas_front_end_model u_fe (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_adc_start(o_adc_start),
      .i_adc_channel(o_adc_channel), .i_delay(delay), .i_core_code(core_code),
      .i_other_code(other_code), .o_adc_done(i_adc_done), .o_adc_code(i_adc_code));
   task automatic chk(string name, logic [9:0] seen, logic [9:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic idle(int n);
      repeat (n) @(negedge i_core_clk);
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(negedge i_core_clk) {i_reg_addr, i_reg_wdata, i_reg_wr} = {a, d, 1'b1};
      @(negedge i_core_clk) i_reg_wr = 1'b0;
   endtask
   // read data is registered, so it is taken a cycle after the strobe
   task automatic rd(logic [7:0] a);
      @(negedge i_core_clk) {i_reg_addr, i_reg_rd} = {a, 1'b1};
      @(negedge i_core_clk) i_reg_rd = 1'b0;
      @(negedge i_core_clk) rd_val = o_reg_rdata;
   endtask
   task automatic status_read();
      @(negedge i_core_clk) i_status_read = 1'b1;
      @(negedge i_core_clk) i_status_read = 1'b0;
      idle(4);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // reset values and an unmapped read
   task automatic t_reset();
      logic [7:0] addr[5] = '{8'h46, 8'h47, 8'h55, 8'h73, 8'h10};
      logic [7:0] exp[5] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 5; i++) begin
         rd(addr[i]);
         chk("reset reg", rd_val, exp[i]);
      end
   endtask
   // sample period for the rail, measured with a slow front end
   task automatic t_period();
      int n;
      delay = 4'hf;
      for (int k = 0; k < 300 && !(o_adc_start === 1'b1 && o_adc_channel === 3'h1); k++) idle(1);
      n = 0;
      do begin
         idle(1);
         n++;
      end while (o_adc_start !== 1'b1 && n < 100);
      chk("period", n, 20);
      delay = 4'h3;
   endtask
   // averaged results, extended bits, then the lock on extended read
   task automatic t_values_lock();
      idle(2500);
      rd(8'h76);
      chk("ext1", rd_val, 8'h14);
      rd(8'h21);
      chk("core", rd_val, 8'haa);
      rd(8'h22);
      chk("supply", rd_val, 8'h19);
      rd(8'h76);
      core_code = 10'h1f0;
      idle(2500);
      rd(8'h21);
      chk("locked core", rd_val, 8'haa);
      idle(2500);
      rd(8'h21);
      chk("released core", rd_val, 8'h7c);
   endtask
   // limit crossing, persistence through a read, release once back in limits
   task automatic t_alarm(logic [7:0] a, logic [7:0] bad, logic [7:0] good);
      wr(a, bad);
      idle(2500);
      chk("alarm", o_core_rail_alarm, 1);
      chk("alert oe", o_alert_out_n_oe, 1);
      chk("alert pin", o_alert_out_n, 0);
      status_read();
      chk("alarm held", o_core_rail_alarm, 1);
      wr(a, good);
      idle(2500);
      status_read();
      chk("alarm clear", o_core_rail_alarm, 0);
      chk("alert released", o_alert_out_n_oe, 0);
   endtask
   // single channel, every code, averaging off, then both temperature formats
   task automatic t_single();
      logic [2:0] codes[5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
      wr(8'h73, 8'h70);
      chk("bypass", o_atten_bypass, 1);
      for (int i = 0; i < 5; i++) begin
         wr(8'h55, {codes[i], 5'h00});
         idle(2000);
         chk("single channel", o_adc_channel, codes[i]);
      end
      wr(8'h55, 8'ha0);
      idle(600);
      rd(8'h77);
      chk("ext2", rd_val, 8'h54);
      rd(8'h25);
      chk("twos", rd_val, 8'h19);
      i_twos_complement = 1'b0;
      idle(200);
      rd(8'h25);
      chk("offset64", rd_val, 8'h59);
   endtask
   initial begin
      idle(8);
      chk("reset channel", o_adc_channel, 1);
      chk("reset oe", o_alert_out_n_oe, 0);
      i_rst_n = 1'b1;
      t_reset();
      t_period();
      t_values_lock();
      t_alarm(8'h47, 8'h70, 8'hff);
      t_alarm(8'h46, 8'h80, 8'h00);
      t_single();
      close_out();
   end
   // about twice the expected run time
   initial begin
      #200000;
      failures++;
      close_out();
   end
endmodule // test_vtas_adc_sequencer
